// ==== sim/bst_far_model.sv ====
// Loopback wiring, trigger connectors, memories and bus controller around the sequencer.
`timescale 1ns/1ps
`default_nettype none
module bst_far_model
	import bst_pkg::*;
(
	input  wire logic       clk_in,
	input  wire logic       rstn_in,
	input  wire logic [7:0] rom_addr_in,
	output logic [7:0]      rom_data_out,
	input  wire logic [3:0] ram_addr_in,
	input  wire logic [7:0] ram_wdata_in,
	input  wire logic       ram_we_in,
	output logic [7:0]      ram_rdata_out,
	input  wire logic       cfg_rd_req_in,
	output logic            cfg_done_out,
	output logic            cfg_ack_out,
	input  wire logic [3:0] lb_bits_in,
	input  wire logic [3:0] lb_oe_in,
	output logic [3:0]      lb_bits_out,
	output logic            din_out,
	input  wire logic [7:0] dout_data_in,
	input  wire logic       dout_wr_in,
	input  wire logic       listen_in,
	output logic            byte_done_out,
	output logic [2:0]      hs_lines_out,
	output logic            dio1_out,
	input  wire logic       get_req_in,
	input  wire logic [6:0] trig_drive_in,
	output logic [7:0]      trig_sense_out,
	input  wire logic [3:0] fault_in
);
	logic [7:0] ram [16];
	logic [2:0] cfg_cnt;
	logic [3:0] hs_cnt;

	always_comb begin
		rom_data_out = rom_addr_in;
		if (rom_addr_in == ROM_SUM_LO) rom_data_out = 8'h83 ^ {7'h0, fault_in[0]};
		if (rom_addr_in == ROM_SUM_HI) rom_data_out = 8'h7d;
	end

	always_ff @(posedge clk_in) if (ram_we_in) ram[ram_addr_in] <= ram_wdata_in;
	assign ram_rdata_out = ram[ram_addr_in];

	always_ff @(posedge clk_in) begin
		cfg_cnt <= (rstn_in && cfg_rd_req_in && !cfg_done_out) ? cfg_cnt + 3'h1 : 3'h0;
		cfg_done_out <= rstn_in && cfg_rd_req_in && cfg_cnt == 3'h5;
	end
	assign cfg_ack_out = cfg_done_out && !fault_in[1];

	always_comb for (int j = 0; j < 4; j++) lb_bits_out[j] = lb_oe_in[j] ? lb_bits_in[j] : lb_bits_in[(j + 3) % 4];

	assign din_out = !fault_in[2];

	always_ff @(posedge clk_in) begin
		if (!rstn_in) begin
			hs_cnt <= 4'h0;
			hs_lines_out <= 3'h7;
			byte_done_out <= 1'b0;
			dio1_out <= 1'b1;
		end else if (dout_wr_in) begin
			hs_cnt <= 4'h1;
			byte_done_out <= 1'b0;
			dio1_out <= !dout_data_in[0];
		end else if (hs_cnt != 4'h0) begin
			hs_cnt <= hs_cnt + 4'h1;
			if (listen_in) hs_lines_out <= hs_lines_out ^ hs_cnt[2:0];
			if (hs_cnt == 4'hf) byte_done_out <= listen_in;
		end
	end

	always_comb begin
		trig_sense_out = {!get_req_in, 1'b1, ~trig_drive_in[5:0]};
		if (fault_in[3]) trig_sense_out[1:0] = {2{&trig_sense_out[1:0]}};
	end
endmodule
`default_nettype wire

// ==== sim/bst_sequencer_chk.sv ====
// Port assertions for the self-test sequencer.
`timescale 1ns/1ps
`default_nettype none
module bst_sequencer_chk (
	input wire logic        ref_clk_in,
	input wire logic        rstn_in,
	input wire logic        start_in,
	input wire logic        busy_out,
	input wire logic        paused_out,
	input wire logic        done_out,
	input wire logic        fail_flag_out,
	input wire logic [11:0] current_num_out,
	input wire logic        ram_we_out,
	input wire logic        cfg_rd_req_out,
	input wire logic        cfg_done_in,
	input wire logic [3:0]  loopback_port_oe_out,
	input wire logic        dout_wr_out,
	input wire logic        assist_listen_out,
	input wire logic        get_req_out,
	input wire logic [6:0]  trigger_drive_lines_out
);
	default clocking cb @(posedge ref_clk_in); endclocking
	default disable iff (!rstn_in);

	sequence s_take;
		start_in && !busy_out;
	endsequence

	// The number may move on one edge before the strobe drops.
	property p_in(en, code);
		en |-> (current_num_out == code || $past(current_num_out) == code);
	endproperty

	a_start_busy: assert property (s_take |=> busy_out && !done_out)
		else $error("start not taken");
	a_done_idle: assert property (done_out |-> !busy_out && !paused_out)
		else $error("done while running");
	a_fail_done: assert property ($rose(fail_flag_out) |-> done_out)
		else $error("fail flag before done");
	a_pause_busy: assert property (paused_out |-> busy_out)
		else $error("pause outside run");
	a_ram_own: assert property (p_in(ram_we_out, 12'hca0))
		else $error("ram write outside memory test");
	a_cfg_own: assert property (p_in(cfg_rd_req_out, 12'hcc0))
		else $error("config read outside its test");
	a_cfg_hold: assert property (cfg_rd_req_out && !cfg_done_in |=> cfg_rd_req_out)
		else $error("config request dropped early");
	a_listen_own: assert property (p_in(assist_listen_out, 12'hd01))
		else $error("listener outside handshake test");
	a_wr_pulse: assert property (dout_wr_out |=> !dout_wr_out)
		else $error("data-out write longer than a cycle");
	a_oe_pairs: assert property (loopback_port_oe_out != 4'hf |-> loopback_port_oe_out inside {4'h5, 4'ha})
		else $error("bad port direction pair");
	a_one_source: assert property ($onehot0({get_req_out, trigger_drive_lines_out}))
		else $error("two trigger sources at once");
endmodule
`default_nettype wire

// ==== sim/tb_bst_sequencer.sv ====
// Self-checking bench for the self-test sequencer.
`timescale 1ns/1ps
`default_nettype none
module tb_bst_sequencer;
	import bst_pkg::*;
	logic        ref_clk_in = 1'b0;
	logic        rstn_in = 1'b0;
	logic        start_in = 1'b0;
	logic        stop_in = 1'b0;
	logic        step_confirm_in = 1'b0;
	logic        review_next_in = 1'b0;
	logic [2:0]  test_sel_in = 3'h7;
	logic [1:0]  mode_in = 2'h0;
	logic [3:0]  fault = 4'h0;
	logic        busy_out, paused_out, done_out, fail_flag_out, review_valid_out, ram_we_out, get_req_out;
	logic        cfg_rd_req_out, cfg_done_in, cfg_ack_in, digital_input_sense_bit_in, dout_wr_out;
	logic        byte_out_done_in, assist_listen_out, bus_line_one_sense_bit_in;
	logic [11:0] current_num_out, review_num_out;
	logic [7:0]  rom_addr_out, rom_data_in, ram_wdata_out, ram_rdata_in, dout_data_out, trigger_sense_lines_in;
	logic [3:0]  ram_addr_out, loopback_port_bits_out, loopback_port_oe_out, loopback_port_bits_in;
	logic [2:0]  hs;
	logic [6:0]  trigger_drive_lines_out;
	logic [11:0] seen[$], want[$];
	int          num_errors = 0;
	int          samples_checked = 0;
	int          pauses, cycles;

	always #12.5 ref_clk_in = ~ref_clk_in;

	bst_sequencer u_dut (.*, .buffered_not_ready_for_data_in(hs[0]), .buffered_not_data_accepted_in(hs[1]),
		.buffered_data_valid_in(hs[2]));
	bst_far_model u_far (.clk_in(ref_clk_in), .rstn_in(rstn_in), .rom_addr_in(rom_addr_out), .rom_data_out(rom_data_in),
		.ram_addr_in(ram_addr_out), .ram_wdata_in(ram_wdata_out), .ram_we_in(ram_we_out), .ram_rdata_out(ram_rdata_in),
		.cfg_rd_req_in(cfg_rd_req_out), .cfg_done_out(cfg_done_in), .cfg_ack_out(cfg_ack_in),
		.lb_bits_in(loopback_port_bits_out), .lb_oe_in(loopback_port_oe_out), .lb_bits_out(loopback_port_bits_in),
		.din_out(digital_input_sense_bit_in), .dout_data_in(dout_data_out), .dout_wr_in(dout_wr_out),
		.listen_in(assist_listen_out), .byte_done_out(byte_out_done_in), .hs_lines_out(hs),
		.dio1_out(bus_line_one_sense_bit_in), .get_req_in(get_req_out), .trig_drive_in(trigger_drive_lines_out),
		.trig_sense_out(trigger_sense_lines_in), .fault_in(fault));

	task automatic tick();
		@(posedge ref_clk_in);
		#2;
	endtask

	task automatic chk(string what, logic [11:0] exp, logic [11:0] got);
		samples_checked++;
		if (got !== exp) begin
			num_errors++;
			$display("BAD %s exp %h got %h", what, exp, got);
		end
	endtask

	task automatic close_out();
		if (num_errors == 0 && samples_checked > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	// Follows one run to its end, confirming every pause and asking to stop from cycle stop_at.
	task automatic run(logic [2:0] sel, logic [1:0] md, int stop_at);
		seen.delete();
		pauses = 0;
		test_sel_in = sel;
		mode_in = md;
		start_in = 1'b1;
		tick();
		start_in = 1'b0;
		tick();
		for (cycles = 0; !done_out; cycles++) begin
			tick();
			if (cycles > 40000) begin
				chk("run timeout", 12'h0, 12'h1);
				close_out();
			end
			if (busy_out && (seen.size() == 0 || seen[$] !== current_num_out)) seen.push_back(current_num_out);
			if (paused_out && !step_confirm_in) pauses++;
			step_confirm_in = paused_out;
			stop_in = (cycles >= stop_at);
		end
		stop_in = 1'b0;
		step_confirm_in = 1'b0;
	endtask

	task automatic cmp_seq(string what);
		chk(what, 12'(want.size()), 12'(seen.size()));
		foreach (want[i]) if (i < seen.size()) chk(what, want[i], seen[i]);
	endtask

	task automatic review(logic [11:0] exp, logic v);
		review_next_in = 1'b1;
		tick();
		review_next_in = 1'b0;
		repeat (3) tick();
		chk("review valid", 12'(v), 12'(review_valid_out));
		if (v) chk("review num", exp, review_num_out);
	endtask

	initial begin
		repeat (10) tick();
		chk("reset oe", 12'hf, 12'(loopback_port_oe_out));
		chk("reset busy", 12'h0, 12'(busy_out));
		rstn_in = 1'b1;
		want = '{12'hc80, 12'hca0, 12'hcc0};
		for (int i = 1; i < 6; i++) want.push_back({7'h67, 5'(i)});
		for (int i = 1; i < 3; i++) want.push_back({7'h68, 5'(i)});
		for (int i = 1; i < 9; i++) want.push_back({7'h69, 5'(i)});
		for (int i = 11; i < 19; i++) want.push_back({7'h69, 5'(i)});
		run(3'h7, MODE_SINGLE, 99999);
		cmp_seq("order all");
		chk("fail flag good", 12'h0, 12'(fail_flag_out));
		fault = 4'hf;
		run(3'h6, MODE_SINGLE, 99999);
		cmp_seq("order faulty");
		chk("fail flag bad", 12'h1, 12'(fail_flag_out));
		want = '{12'hc80, 12'hcc0, {7'h67, 5'h5}, {7'h69, 5'hb}, {7'h69, 5'hc}};
		foreach (want[i]) review(want[i], 1'b1);
		review(12'h0, 1'b0);
		fault = 4'h0;
		want = '{};
		for (int i = 1; i < 6; i++) want.push_back({7'h67, 5'(i)});
		run(3'h3, MODE_STEP, 99999);
		cmp_seq("order step");
		chk("pauses", 12'h4, 12'(pauses));
		chk("fail flag cleared", 12'h0, 12'(fail_flag_out));
		run(3'h2, MODE_CONT, 300);
		chk("continuous length", 12'h1, 12'(cycles > 300));
		chk("continuous num", 12'hcc0, seen[0]);
		close_out();
	end
endmodule

bind bst_sequencer bst_sequencer_chk u_chk (.*);
`default_nettype wire

// ==== verilog/bst_fail_log.sv ====
// Per sub-test pass/fail record with a search for the next failed entry.
`timescale 1ns/1ps
`default_nettype none
module bst_fail_log
	import bst_pkg::*;
(
	input  wire logic       clk_in,
	input  wire logic       rstn_in,
	input  wire logic       clr_in,
	input  wire logic       rec_in,
	input  wire logic [4:0] rec_idx_in,
	input  wire logic       rec_fail_in,
	input  wire logic [4:0] from_in,
	output logic            any_out,
	output logic [4:0]      next_idx_out,
	output logic            next_valid_out
);
	logic [NUM_SUB-1:0] fails;

	always_ff @(posedge clk_in) begin
		if (!rstn_in || clr_in) fails <= '0;
		else if (rec_in) fails[rec_idx_in] <= rec_fail_in;
	end

	assign any_out = |fails;

	// First failed index at or after from_in.
	always_comb begin
		next_idx_out   = 5'h00;
		next_valid_out = 1'b0;
		for (int i = NUM_SUB - 1; i >= 0; i--) begin
			if (fails[i] && 5'(i) >= from_in) begin
				next_idx_out   = 5'(i);
				next_valid_out = 1'b1;
			end
		end
	end
endmodule
`default_nettype wire

// ==== verilog/bst_pkg.sv ====
// Constants, sub-test numbering and timing for the built-in self-test sequencer.
package bst_pkg;

	// ----------------------------------------------------------------
	// Timing
	// ----------------------------------------------------------------
	localparam int          CLK_NS      = 25;
	localparam int          SETTLE_NS   = 1000;
	localparam int          TIMEOUT_NS  = 100000;
	localparam logic [11:0] SETTLE_CNT  = 12'((SETTLE_NS + CLK_NS - 1) / CLK_NS);
	localparam logic [11:0] TIMEOUT_CNT = 12'(TIMEOUT_NS / CLK_NS);

	// ----------------------------------------------------------------
	// Memories
	// ----------------------------------------------------------------
	localparam logic [7:0] ROM_SUM_LO = 8'hfe;
	localparam logic [7:0] ROM_SUM_HI = 8'hff;
	localparam logic [3:0] RAM_LAST   = 4'hf;

	// ----------------------------------------------------------------
	// Sub-test indices
	// ----------------------------------------------------------------
	localparam logic [4:0] SUB_ROM    = 5'h00;
	localparam logic [4:0] SUB_RAM    = 5'h01;
	localparam logic [4:0] SUB_CFG    = 5'h02;
	localparam logic [4:0] SUB_DOUT0  = 5'h03;
	localparam logic [4:0] SUB_DIN    = 5'h07;
	localparam logic [4:0] SUB_HS     = 5'h08;
	localparam logic [4:0] SUB_DATA   = 5'h09;
	localparam logic [4:0] SUB_TRIG0  = 5'h0a;
	localparam logic [4:0] SUB_EXT    = 5'h10;
	localparam logic [4:0] SUB_GET    = 5'h11;
	localparam logic [4:0] SUB_SHORT0 = 5'h12;
	localparam logic [4:0] SUB_LAST   = 5'h19;
	localparam int         NUM_SUB    = 26;

	localparam logic [3:0] GET_SRC = 4'h7;
	localparam logic [3:0] SRC_END = 4'h8;

	// ----------------------------------------------------------------
	// Modes, selections and bus bytes
	// ----------------------------------------------------------------
	localparam logic [1:0] MODE_SINGLE = 2'h0;
	localparam logic [1:0] MODE_CONT   = 2'h1;
	localparam logic [1:0] MODE_STEP   = 2'h2;
	localparam logic [7:0] HS_BYTE     = 8'h55;
	localparam logic [7:0] DIO1_DRIVE  = 8'h01;
	localparam logic [7:0] DIO1_FREE   = 8'h00;

	// Test number as {major, minor}; 7'h64 is test 100.
	function automatic logic [11:0] bst_num(input logic [4:0] i);
		logic [6:0] mj;
		logic [4:0] mn;
		mj = 7'h64;
		mn = 5'h00;
		if (i == SUB_ROM) mj = 7'h64;
		else if (i == SUB_RAM) mj = 7'h65;
		else if (i == SUB_CFG) mj = 7'h66;
		else if (i < SUB_HS) begin
			mj = 7'h67;
			mn = 5'(i - 5'h02);
		end else if (i < SUB_TRIG0) begin
			mj = 7'h68;
			mn = 5'(i - 5'h07);
		end else if (i < SUB_SHORT0) begin
			mj = 7'h69;
			mn = 5'(i - 5'h09);
		end else if (i != SUB_ROM) begin
			mj = 7'h69;
			mn = 5'(i - 5'h07);
		end
		return {mj, mn};
	endfunction

	// Index range {first, last} of a major test; any other selection runs all.
	function automatic logic [9:0] bst_range(input logic [2:0] sel);
		case (sel)
			3'h0: return {SUB_ROM, SUB_ROM};
			3'h1: return {SUB_RAM, SUB_RAM};
			3'h2: return {SUB_CFG, SUB_CFG};
			3'h3: return {SUB_DOUT0, SUB_DIN};
			3'h4: return {SUB_HS, SUB_DATA};
			3'h5: return {SUB_TRIG0, SUB_LAST};
			default: return {SUB_ROM, SUB_LAST};
		endcase
	endfunction

endpackage

// ==== verilog/bst_sequencer.sv ====
// Built-in self-test sequencer: runs numbered sub-tests and logs failures.
`timescale 1ns/1ps
`default_nettype none

// Contract
// - Test 100: checksum program memory against stored
// - Test 101: write, read back working memory
// - Test 102: config memory read must acknowledge
// - Port bits four to seven drive outputs
// - Loopback returns each output to next bit
// - 103.1: drive bit four, check bit five
// - 103.2: drive bit five, check bit six
// - 103.3 and 103.4 check outputs three, four
// - 103.5: open digital input reads high
// - 104.1: byte-out handshake via test assist
// - 104.2: drive, release DIO1, sense each
// - Seven trigger outputs, eight trigger inputs
// - Output seven ready, inputs seven, eight
// - Bus lines idle high, pulled down
// - 105.1-105.6: pulse line, trigger expected
// - 105.7: trigger seen means short, fault
// - 105.8: bus group trigger must register
// - 105.11-105.18: other sources must not trigger
// - Failed run flagged, failures reviewable
// - Handshake test exercises three handshake lines
// - Single, continuous and step modes
module bst_sequencer
	import bst_pkg::*;
(
	input  wire logic       ref_clk_in,
	input  wire logic       rstn_in,
	input  wire logic       start_in,
	input  wire logic       stop_in,
	input  wire logic       step_confirm_in,
	input  wire logic       review_next_in,
	input  wire logic [2:0] test_sel_in,
	input  wire logic [1:0] mode_in,
	output logic            busy_out,
	output logic            paused_out,
	output logic            done_out,
	output logic            fail_flag_out,
	output logic [11:0]     current_num_out,
	output logic [11:0]     review_num_out,
	output logic            review_valid_out,
	output logic [7:0]      rom_addr_out,
	input  wire logic [7:0] rom_data_in,
	output logic [3:0]      ram_addr_out,
	output logic [7:0]      ram_wdata_out,
	output logic            ram_we_out,
	input  wire logic [7:0] ram_rdata_in,
	output logic            cfg_rd_req_out,
	input  wire logic       cfg_done_in,
	input  wire logic       cfg_ack_in,
	output logic [3:0]      loopback_port_bits_out,
	output logic [3:0]      loopback_port_oe_out,
	input  wire logic [3:0] loopback_port_bits_in,
	input  wire logic       digital_input_sense_bit_in,
	output logic [7:0]      dout_data_out,
	output logic            dout_wr_out,
	input  wire logic       byte_out_done_in,
	output logic            assist_listen_out,
	input  wire logic       buffered_not_ready_for_data_in,
	input  wire logic       buffered_not_data_accepted_in,
	input  wire logic       buffered_data_valid_in,
	input  wire logic       bus_line_one_sense_bit_in,
	output logic            get_req_out,
	output logic [6:0]      trigger_drive_lines_out,
	input  wire logic [7:0] trigger_sense_lines_in
);
	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	typedef enum {
		ST_IDLE, ST_SETUP, ST_ROM, ST_RAM_WR, ST_RAM_RD, ST_CFG, ST_LOOP,
		ST_DIN, ST_HS, ST_DATA, ST_TRIG, ST_JUDGE, ST_PAUSE
	} bst_state_e;

	bst_state_e  state;
	logic [4:0]  sub;
	logic [4:0]  first;
	logic [4:0]  last;
	logic [1:0]  mode;
	logic [2:0]  phase;
	logic [11:0] cnt;
	logic [15:0] acc;
	logic [7:0]  sum_lo;
	logic        fault;
	logic        stop_req;
	logic [2:0]  arm;
	logic [3:0]  src;
	logic        short_test;
	logic        trig_clear;
	logic [2:0]  hs_prev;
	logic [2:0]  hs_seen;
	logic [4:0]  review_from;

	logic       trig_hit;
	logic       log_any;
	logic [4:0] log_next;
	logic       log_next_valid;
	logic       run_start;
	logic       judge;
	logic [1:0] lp;
	logic [2:0] hs_now;
	logic [2:0] hs_seen_now;
	logic [3:0] src_next;
	logic [9:0] sel_range;

	assign run_start   = start_in && !busy_out;
	assign judge       = (state == ST_JUDGE);
	assign lp          = 2'(sub - SUB_DOUT0);
	assign hs_now      = {buffered_not_ready_for_data_in, buffered_not_data_accepted_in, buffered_data_valid_in};
	assign hs_seen_now = hs_seen | (hs_prev ^ hs_now);
	assign src_next    = (4'(src + 4'h1) == {1'b0, arm}) ? 4'(src + 4'h2) : 4'(src + 4'h1);
	assign sel_range   = bst_range(test_sel_in);

	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	bst_trig_latch u_trig (
		.clk_in   (ref_clk_in),
		.rstn_in  (rstn_in),
		.sense_in (trigger_sense_lines_in),
		.arm_in   (arm),
		.clear_in (trig_clear),
		.hit_out  (trig_hit)
	);

	bst_fail_log u_log (
		.clk_in         (ref_clk_in),
		.rstn_in        (rstn_in),
		.clr_in         (run_start),
		.rec_in         (judge),
		.rec_idx_in     (sub),
		.rec_fail_in    (fault),
		.from_in        (review_from),
		.any_out        (log_any),
		.next_idx_out   (log_next),
		.next_valid_out (log_next_valid)
	);

	// ----------------------------------------------------------------
	// Run control
	// ----------------------------------------------------------------
	// Stop is honoured at the end of the current sub-test.
	always_ff @(posedge ref_clk_in) begin
		if (!rstn_in || run_start) stop_req <= 1'b0;
		else if (stop_in && busy_out) stop_req <= 1'b1;
	end

	always_ff @(posedge ref_clk_in) begin
		if (!rstn_in || run_start) begin
			review_from      <= 5'h00;
			review_num_out   <= 12'h000;
			review_valid_out <= 1'b0;
		end else if (done_out && fail_flag_out && review_next_in) begin
			if (log_next_valid) begin
				review_num_out   <= bst_num(log_next);
				review_from      <= 5'(log_next + 5'h01);
				review_valid_out <= 1'b1;
			end else begin
				review_from      <= 5'h00;
				review_valid_out <= 1'b0;
			end
		end
	end

	// ----------------------------------------------------------------
	// Sequencer
	// ----------------------------------------------------------------
	always_ff @(posedge ref_clk_in) begin
		if (!rstn_in) begin
			state                   <= ST_IDLE;
			sub                     <= SUB_ROM;
			first                   <= SUB_ROM;
			last                    <= SUB_ROM;
			mode                    <= MODE_SINGLE;
			phase                   <= 3'h0;
			cnt                     <= 12'h000;
			acc                     <= 16'h0000;
			sum_lo                  <= 8'h00;
			fault                   <= 1'b0;
			arm                     <= 3'h0;
			src                     <= 4'h0;
			short_test              <= 1'b0;
			trig_clear              <= 1'b0;
			hs_prev                 <= 3'h0;
			hs_seen                 <= 3'h0;
			busy_out                <= 1'b0;
			paused_out              <= 1'b0;
			done_out                <= 1'b0;
			fail_flag_out           <= 1'b0;
			current_num_out         <= 12'h000;
			rom_addr_out            <= 8'h00;
			ram_addr_out            <= 4'h0;
			ram_wdata_out           <= 8'h00;
			ram_we_out              <= 1'b0;
			cfg_rd_req_out          <= 1'b0;
			loopback_port_bits_out  <= 4'h0;
			loopback_port_oe_out    <= 4'hf;
			dout_data_out           <= 8'h00;
			dout_wr_out             <= 1'b0;
			assist_listen_out       <= 1'b0;
			get_req_out             <= 1'b0;
			trigger_drive_lines_out <= 7'h00;
		end else begin
			dout_wr_out <= 1'b0;
			trig_clear  <= 1'b0;
			if (cnt != 12'h000) cnt <= 12'(cnt - 12'h001);
			case (state)
				ST_IDLE: begin
					if (start_in) begin
						{first, last} <= sel_range;
						sub           <= sel_range[9:5];
						mode          <= mode_in;
						busy_out      <= 1'b1;
						done_out      <= 1'b0;
						fail_flag_out <= 1'b0;
						state         <= ST_SETUP;
					end
				end
				ST_SETUP: begin
					current_num_out <= bst_num(sub);
					paused_out      <= 1'b0;
					phase           <= 3'h0;
					fault           <= 1'b0;
					acc             <= 16'h0000;
					rom_addr_out    <= 8'h00;
					ram_addr_out    <= 4'h0;
					if (sub == SUB_ROM) state <= ST_ROM;
					else if (sub == SUB_RAM) begin
						ram_wdata_out <= {4'h0, 4'hf};
						ram_we_out    <= 1'b1;
						state         <= ST_RAM_WR;
					end else if (sub == SUB_CFG) state <= ST_CFG;
					else if (sub < SUB_DIN) state <= ST_LOOP;
					else if (sub == SUB_DIN) state <= ST_DIN;
					else if (sub == SUB_HS) state <= ST_HS;
					else if (sub == SUB_DATA) state <= ST_DATA;
					else if (sub < SUB_SHORT0) begin
						arm        <= 3'(sub - SUB_TRIG0);
						src        <= {1'b0, 3'(sub - SUB_TRIG0)};
						short_test <= 1'b0;
						state      <= ST_TRIG;
					end else begin
						arm        <= 3'(sub - SUB_SHORT0);
						src        <= (sub == SUB_SHORT0) ? 4'h1 : 4'h0;
						short_test <= 1'b1;
						state      <= ST_TRIG;
					end
				end
				ST_ROM: begin
					rom_addr_out <= 8'(rom_addr_out + 8'h01);
					if (rom_addr_out < ROM_SUM_LO) acc <= 16'(acc + {8'h00, rom_data_in});
					else if (rom_addr_out == ROM_SUM_LO) sum_lo <= rom_data_in;
					else begin
						fault <= (acc != {rom_data_in, sum_lo});
						state <= ST_JUDGE;
					end
				end
				ST_RAM_WR: begin
					if (ram_addr_out == RAM_LAST) begin
						ram_we_out   <= 1'b0;
						ram_addr_out <= 4'h0;
						state        <= ST_RAM_RD;
					end else begin
						ram_addr_out  <= 4'(ram_addr_out + 4'h1);
						ram_wdata_out <= {4'(ram_addr_out + 4'h1), ~4'(ram_addr_out + 4'h1)};
					end
				end
				ST_RAM_RD: begin
					if (ram_rdata_in != {ram_addr_out, ~ram_addr_out}) fault <= 1'b1;
					ram_addr_out <= 4'(ram_addr_out + 4'h1);
					if (ram_addr_out == RAM_LAST) state <= ST_JUDGE;
				end
				ST_CFG: begin
					if (phase == 3'h0) begin
						cfg_rd_req_out <= 1'b1;
						cnt            <= TIMEOUT_CNT;
						phase          <= 3'h1;
					end else if (cfg_done_in || cnt == 12'h000) begin
						cfg_rd_req_out <= 1'b0;
						fault          <= !(cfg_done_in && cfg_ack_in);
						state          <= ST_JUDGE;
					end
				end
				ST_LOOP: begin
					if (phase == 3'h0) begin
						loopback_port_oe_out   <= (4'h1 << lp) | (4'h1 << 2'(lp + 2'h2));
						loopback_port_bits_out <= 4'h1 << lp;
						cnt                    <= SETTLE_CNT;
						phase                  <= 3'h1;
					end else if (cnt == 12'h000) begin
						if (loopback_port_bits_in[2'(lp + 2'h1)] != (phase == 3'h1)) fault <= 1'b1;
						loopback_port_bits_out <= 4'h0;
						cnt                    <= SETTLE_CNT;
						phase                  <= 3'h2;
						if (phase == 3'h2) begin
							loopback_port_oe_out <= 4'hf;
							state                <= ST_JUDGE;
						end
					end
				end
				ST_DIN: begin
					fault <= !digital_input_sense_bit_in;
					state <= ST_JUDGE;
				end
				ST_HS: begin
					hs_prev <= hs_now;
					if (phase == 3'h0) begin
						assist_listen_out <= 1'b1;
						dout_data_out     <= HS_BYTE;
						dout_wr_out       <= 1'b1;
						hs_seen           <= 3'h0;
						cnt               <= TIMEOUT_CNT;
						phase             <= 3'h1;
					end else begin
						hs_seen <= hs_seen_now;
						if (byte_out_done_in || cnt == 12'h000) begin
							assist_listen_out <= 1'b0;
							fault             <= !byte_out_done_in || (hs_seen_now != 3'h7);
							state             <= ST_JUDGE;
						end
					end
				end
				ST_DATA: begin
					// driven line reads low, released high
					if (phase == 3'h0) begin
						dout_data_out <= DIO1_DRIVE;
						dout_wr_out   <= 1'b1;
						cnt           <= SETTLE_CNT;
						phase         <= 3'h1;
					end else if (cnt == 12'h000) begin
						if (bus_line_one_sense_bit_in != (phase == 3'h2)) fault <= 1'b1;
						dout_data_out <= DIO1_FREE;
						dout_wr_out   <= (phase == 3'h1);
						cnt           <= SETTLE_CNT;
						phase         <= 3'h2;
						if (phase == 3'h2) state <= ST_JUDGE;
					end
				end
				ST_TRIG: begin
					case (phase)
						3'h0: begin
							trig_clear <= 1'b1;
							cnt        <= SETTLE_CNT;
							phase      <= 3'h1;
						end
						3'h1: begin
							if (cnt == 12'h000) begin
								if (src == GET_SRC) get_req_out <= 1'b1;
								else trigger_drive_lines_out <= 7'h01 << src[2:0];
								cnt   <= SETTLE_CNT;
								phase <= 3'h2;
							end
						end
						3'h2: begin
							if (cnt == 12'h000) begin
								get_req_out             <= 1'b0;
								trigger_drive_lines_out <= 7'h00;
								cnt                     <= SETTLE_CNT;
								phase                   <= 3'h3;
							end
						end
						default: begin
							if (cnt == 12'h000) begin
								if (short_test && src_next < SRC_END) begin
									src   <= src_next;
									cnt   <= SETTLE_CNT;
									phase <= 3'h1;
								end else begin
									fault <= (short_test || sub == SUB_EXT) ? trig_hit : !trig_hit;
									state <= ST_JUDGE;
								end
							end
						end
					endcase
				end
				ST_JUDGE: begin
					if (sub != last && !stop_req) begin
						sub <= 5'(sub + 5'h01);
						if (mode == MODE_STEP) begin
							paused_out <= 1'b1;
							state      <= ST_PAUSE;
						end else state <= ST_SETUP;
					end else if (mode == MODE_CONT && !stop_req) begin
						sub   <= first;
						state <= ST_SETUP;
					end else begin
						fail_flag_out <= log_any || fault;
						busy_out      <= 1'b0;
						done_out      <= 1'b1;
						state         <= ST_IDLE;
					end
				end
				ST_PAUSE: begin
					if (stop_req) begin
						fail_flag_out <= log_any;
						paused_out    <= 1'b0;
						busy_out      <= 1'b0;
						done_out      <= 1'b1;
						state         <= ST_IDLE;
					end else if (step_confirm_in) state <= ST_SETUP;
				end
				default: state <= ST_IDLE;
			endcase
		end
	end
endmodule
`default_nettype wire

// ==== verilog/bst_trig_latch.sv ====
// Trigger detection latch on the one armed trigger sense line.
`timescale 1ns/1ps
`default_nettype none
module bst_trig_latch
	import bst_pkg::*;
(
	input  wire logic       clk_in,
	input  wire logic       rstn_in,
	input  wire logic [7:0] sense_in,
	input  wire logic [2:0] arm_in,
	input  wire logic       clear_in,
	output logic            hit_out
);
	logic [7:0] prev;

	// Lines idle high, so a trigger is a falling edge.
	always_ff @(posedge clk_in) begin
		if (!rstn_in) prev <= 8'hff;
		else prev <= sense_in;
	end

	// An edge in the clearing cycle still counts.
	always_ff @(posedge clk_in) begin
		if (!rstn_in) hit_out <= 1'b0;
		else if (prev[arm_in] && !sense_in[arm_in]) hit_out <= 1'b1;
		else if (clear_in) hit_out <= 1'b0;
	end
endmodule
`default_nettype wire
